/* File: hw/cmp_vref_regs.vh */
`ifndef CMP_VREF_REGS_VH
`define CMP_VREF_REGS_VH
// Register indices (byte address is index times four, printed values not word aligned)
`define IDX_INTERRUPT_CONTROL 8'h0B
`define IDX_PERIPHERAL_IRQ_FLAGS 8'h0C
`define IDX_COMPARATOR_CONTROL 8'h1F
`define IDX_PORT_A_DIRECTION 8'h85
`define IDX_PERIPHERAL_IRQ_ENABLES 8'h8C
`define IDX_REFERENCE_CONTROL 8'h9F
`define IDX_IRQ_STATUS 8'hA0
`define IDX_IRQ_MASK 8'hA1
`define IDX_SLEEP_CONTROL 8'hA2
// Comparator control fields
`define CMP_MODE_LSB 0
`define CMP_MODE_MSB 2
`define CMP_INPUT_SWITCH_BIT 3
`define CMP1_INVERT_BIT 4
`define CMP2_INVERT_BIT 5
`define CMP1_RESULT_BIT 6
`define CMP2_RESULT_BIT 7
`define CMP_MODE_RESET 3'h0
`define CMP_MODE_INT_REF 3'h2
`define CMP_MODE_PIN_OUT 3'h6
`define CMP_MODE_OFF 3'h7
// Reference control fields
`define REF_POWER_BIT 7
`define REF_PIN_BIT 6
`define REF_RANGE_BIT 5
`define REF_UNUSED_BIT 4
`define REF_TAP_LSB 0
`define REF_TAP_MSB 3
`define REF_WRITE_MASK 8'hEF
// Interrupt control and flag bits
`define GLOBAL_ENABLE_BIT 7
`define PERIPH_ENABLE_BIT 6
`define CHANGE_FLAG_BIT 6
`define PIR_WRITE_MASK 8'hF7
// Reset values
`define CMP_CONTROL_RESET 8'h00
`define REF_CONTROL_RESET 8'h00
`define INTERRUPT_CONTROL_RESET 8'h00
`define PIR_RESET 8'h00
`define PIE_RESET 8'h00
`define PORT_A_DIRECTION_RESET 8'hFF
// AXI responses
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`endif

/* File: hw/comparator_vref_control.v */
`timescale 1ns/100ps
`include "cmp_vref_regs.vh"

// What this block does
// - Comparators and wake interrupt live during sleep
// - Mode 111 switches both comparators off
// - Comparator control kept across wake
// - Reset returns comparator control to 000
// - Comparators powered down throughout reset
// - Bit 7 powers reference ladder
// - Bit 6 drives reference onto pin
// - Bit 5 selects low range when set
// - Four-bit tap sets ladder level
// - Sixteen levels in each range
// - Bit 4 ignores writes, reads zero
// - Reference control kept across wake
// - Reset clears reference power, pin, range, taps
// - Pin gets reference only with direction set
// - Reference independent of comparator mode
// - Mode 010 routes reference to plus inputs
// - Output change sets sticky change flag
module comparator_vref_control #(
   parameter ADDR_W = 10
) (
   input wire sys_clk_in,
   input wire rst_n_in,
   input wire [ADDR_W-1:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output reg s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output reg s_axi_wready_out,
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire [ADDR_W-1:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output reg s_axi_arready_out,
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,
   input wire first_cmp_raw_in,
   input wire second_cmp_raw_in,
   output reg cmp_power_on_out,
   output reg [2:0] cmp_mode_out,
   output reg cmp_input_switch_out,
   output reg cmp_use_int_ref_out,
   output reg cmp_pin_out_en_out,
   output reg reference_power_on_out,
   output reg reference_low_range_out,
   output reg [3:0] reference_tap_select_out,
   output reg reference_pin2_connect_out,
   output reg wake_out,
   output reg cpu_irq_out,
   output reg irq_out
);

   reg [7:0] cmp_ctrl_r;
   reg [7:0] ref_ctrl_r;
   reg [7:0] interrupt_control_r;
   reg [7:0] pir_r;
   reg [7:0] pie_r;
   reg [7:0] port_a_direction_r;
   reg [1:0] irq_status_r;
   reg [1:0] irq_mask_r;
   reg sleep_r;
   reg [1:0] last_result_r;
   reg [ADDR_W-1:0] awaddr_r;
   reg aw_held_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg w_held_r;

   // Byte address of a register index
   function [ADDR_W-1:0] reg_addr;
      input [7:0] idx;
      begin
         reg_addr = {idx, 2'b00};
      end
   endfunction

   // Apply strobe on lane 0 only; registers are 8 bits wide
   function [7:0] merge8;
      input [7:0] old;
      input [7:0] data;
      input strb;
      begin
         merge8 = strb ? data : old;
      end
   endfunction

   wire [2:0] mode = cmp_ctrl_r[`CMP_MODE_MSB:`CMP_MODE_LSB];
   wire cmp_on = (mode != `CMP_MODE_OFF) && (mode != `CMP_MODE_RESET);
   wire inv1 = cmp_ctrl_r[`CMP1_INVERT_BIT];
   wire inv2 = cmp_ctrl_r[`CMP2_INVERT_BIT];
   // Results read as zero while the comparators are off
   wire [1:0] result = cmp_on ?
      {second_cmp_raw_in ^ inv2, first_cmp_raw_in ^ inv1} : 2'b00;
   wire change = (result != last_result_r);

   // Each write channel moves only on its own valid and ready, then waits in a holding slot
   wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
   wire w_take = s_axi_wvalid_in && s_axi_wready_out;
   wire do_write = aw_held_r && w_held_r && !s_axi_bvalid_out;
   wire [ADDR_W-1:0] waddr = awaddr_r;
   wire [31:0] wdata = wdata_r;
   wire wstrb0 = wstrb_r[0];
   wire [7:0] wbyte = wdata[7:0];
   wire do_read = s_axi_arvalid_in && s_axi_arready_out;
   wire rd_cmp = do_read && (s_axi_araddr_in == reg_addr(`IDX_COMPARATOR_CONTROL));

   wire wr_cmp = do_write && (waddr == reg_addr(`IDX_COMPARATOR_CONTROL));
   wire wr_ref = do_write && (waddr == reg_addr(`IDX_REFERENCE_CONTROL));
   wire wr_int = do_write && (waddr == reg_addr(`IDX_INTERRUPT_CONTROL));
   wire wr_pir = do_write && (waddr == reg_addr(`IDX_PERIPHERAL_IRQ_FLAGS));
   wire wr_pie = do_write && (waddr == reg_addr(`IDX_PERIPHERAL_IRQ_ENABLES));
   wire wr_tris = do_write && (waddr == reg_addr(`IDX_PORT_A_DIRECTION));
   wire wr_stat = do_write && (waddr == reg_addr(`IDX_IRQ_STATUS));
   wire wr_mask = do_write && (waddr == reg_addr(`IDX_IRQ_MASK));
   wire wr_sleep = do_write && (waddr == reg_addr(`IDX_SLEEP_CONTROL));
   wire wr_hit = wr_cmp || wr_ref || wr_int || wr_pir || wr_pie || wr_tris ||
      wr_stat || wr_mask || wr_sleep;

   wire flag_pending = pir_r[`CHANGE_FLAG_BIT] && pie_r[`CHANGE_FLAG_BIT];
   wire [1:0] stat_nxt_set = {change, change && cmp_on};
   wire cpu_irq_nxt = flag_pending && interrupt_control_r[`PERIPH_ENABLE_BIT] &&
      interrupt_control_r[`GLOBAL_ENABLE_BIT];

   reg [31:0] rdata_nxt;
   reg rd_hit;
   always @* begin
      rdata_nxt = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr_in)
         reg_addr(`IDX_COMPARATOR_CONTROL): rdata_nxt[7:0] = {result, cmp_ctrl_r[5:0]};
         reg_addr(`IDX_REFERENCE_CONTROL): rdata_nxt[7:0] = ref_ctrl_r & `REF_WRITE_MASK;
         reg_addr(`IDX_INTERRUPT_CONTROL): rdata_nxt[7:0] = interrupt_control_r;
         reg_addr(`IDX_PERIPHERAL_IRQ_FLAGS): rdata_nxt[7:0] = pir_r;
         reg_addr(`IDX_PERIPHERAL_IRQ_ENABLES): rdata_nxt[7:0] = pie_r;
         reg_addr(`IDX_PORT_A_DIRECTION): rdata_nxt[7:0] = port_a_direction_r;
         reg_addr(`IDX_IRQ_STATUS): rdata_nxt[1:0] = irq_status_r;
         reg_addr(`IDX_IRQ_MASK): rdata_nxt[1:0] = irq_mask_r;
         reg_addr(`IDX_SLEEP_CONTROL): rdata_nxt[0] = sleep_r;
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         cmp_ctrl_r <= `CMP_CONTROL_RESET;
         ref_ctrl_r <= `REF_CONTROL_RESET;
         interrupt_control_r <= `INTERRUPT_CONTROL_RESET;
         pir_r <= `PIR_RESET;
         pie_r <= `PIE_RESET;
         port_a_direction_r <= `PORT_A_DIRECTION_RESET;
         irq_status_r <= 2'b00;
         irq_mask_r <= 2'b00;
         sleep_r <= 1'b0;
         last_result_r <= 2'b00;
         aw_held_r <= 1'b0;
         awaddr_r <= {ADDR_W{1'b0}};
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `AXI_RESP_OKAY;
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rresp_out <= `AXI_RESP_OKAY;
         s_axi_rdata_out <= 32'h0000_0000;
      end else begin
         // Reading or writing comparator control ends the mismatch
         if (rd_cmp || wr_cmp)
            last_result_r <= result;
         else
            last_result_r <= last_result_r;
         // Write channels: hold whichever arrives first
         s_axi_awready_out <= !(aw_take || (aw_held_r && !do_write));
         s_axi_wready_out <= !(w_take || (w_held_r && !do_write));
         if (aw_take) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr_in;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end
         if (w_take) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata_in;
            wstrb_r <= s_axi_wstrb_in;
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
         // No new read address while an answer is still waiting
         s_axi_arready_out <= !(do_read || (s_axi_rvalid_out && !s_axi_rready_in));
         if (do_read) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rdata_nxt;
            s_axi_rresp_out <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
         // Result bits are read-only; only low six bits are stored
         if (wr_cmp && wstrb0)
            cmp_ctrl_r <= {2'b00, wbyte[5:0]};
         // No write path from comparator side keeps these apart
         if (wr_ref && wstrb0)
            ref_ctrl_r <= wbyte & `REF_WRITE_MASK;
         if (wr_int)
            interrupt_control_r <= merge8(interrupt_control_r, wbyte, wstrb0);
         if (wr_pie)
            pie_r <= merge8(pie_r, wbyte, wstrb0);
         if (wr_tris)
            port_a_direction_r <= merge8(port_a_direction_r, wbyte, wstrb0);
         if (wr_mask && wstrb0)
            irq_mask_r <= wbyte[1:0];
         // Set beats clear, so a change in the write cycle is kept
         pir_r <= (wr_pir && wstrb0 ? (wbyte & `PIR_WRITE_MASK) : pir_r) |
            ({7'h00, change} << `CHANGE_FLAG_BIT);
         irq_status_r <= (irq_status_r & ~((wr_stat && wstrb0) ? wbyte[1:0] : 2'b00)) |
            stat_nxt_set;
         // Sleep ends on an enabled comparator change flag (bit 6) with peripheral enable set; registers untouched
         if (wr_sleep && wstrb0)
            sleep_r <= wbyte[0];
         else if (flag_pending && interrupt_control_r[`PERIPH_ENABLE_BIT])
            sleep_r <= 1'b0;
      end
   end

   // Outputs registered one cycle after the register contents
   always @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         cmp_power_on_out <= 1'b0;
         cmp_mode_out <= `CMP_MODE_RESET;
         cmp_input_switch_out <= 1'b0;
         cmp_use_int_ref_out <= 1'b0;
         cmp_pin_out_en_out <= 1'b0;
         reference_power_on_out <= 1'b0;
         reference_low_range_out <= 1'b0;
         reference_tap_select_out <= 4'h0;
         reference_pin2_connect_out <= 1'b0;
         wake_out <= 1'b0;
         cpu_irq_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         // Sleep has no effect on comparator power
         cmp_power_on_out <= cmp_on;
         cmp_mode_out <= mode;
         cmp_input_switch_out <= cmp_ctrl_r[`CMP_INPUT_SWITCH_BIT];
         cmp_use_int_ref_out <= (mode == `CMP_MODE_INT_REF);
         cmp_pin_out_en_out <= (mode == `CMP_MODE_PIN_OUT);
         reference_power_on_out <= ref_ctrl_r[`REF_POWER_BIT];
         reference_low_range_out <= ref_ctrl_r[`REF_RANGE_BIT];
         // Ladder decodes all sixteen codes per range
         reference_tap_select_out <= ref_ctrl_r[`REF_TAP_MSB:`REF_TAP_LSB];
         reference_pin2_connect_out <= ref_ctrl_r[`REF_PIN_BIT] &&
            port_a_direction_r[2];
         wake_out <= sleep_r && flag_pending && interrupt_control_r[`PERIPH_ENABLE_BIT];
         cpu_irq_out <= cpu_irq_nxt;
         irq_out <= |(irq_status_r & irq_mask_r);
      end
   end

endmodule // comparator_vref_control

/* File: tb/comparator_vref_control_monitor.sv */
`timescale 1ns/100ps
module comparator_vref_control_monitor (
   input wire sys_clk_in,
   input wire rst_n_in,
   input wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire s_axi_rvalid_out,
   input wire s_axi_rready_in,
   input wire [31:0] s_axi_rdata_out,
   input wire cmp_power_on_out,
   input wire [2:0] cmp_mode_out,
   input wire cmp_use_int_ref_out,
   input wire reference_power_on_out,
   input wire reference_low_range_out,
   input wire [3:0] reference_tap_select_out,
   input wire reference_pin2_connect_out
);
   reg [2:0] age_r;
   wire [6:0] ref_v;
   assign ref_v = {reference_power_on_out, reference_low_range_out,
      reference_pin2_connect_out, reference_tap_select_out};
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Cycles since the last write answer; control outputs may move only just after one
   always @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         age_r <= 3'h7;
      end else if (s_axi_bvalid_out) begin
         age_r <= 3'h0;
      end else if (age_r != 3'h7) begin
         age_r <= age_r + 3'h1;
      end
   end
   property p_rst_vals;
      $rose(rst_n_in) |-> !cmp_power_on_out && !reference_power_on_out && ref_v == 7'h00
         && cmp_mode_out == 3'h0;
   endproperty
   property p_cmp_pwr;
      cmp_power_on_out == (cmp_mode_out != 3'h0 && cmp_mode_out != 3'h7);
   endproperty
   property p_int_ref;
      cmp_use_int_ref_out == (cmp_mode_out == 3'h2);
   endproperty
   property p_ref_hold;
      $changed(ref_v) |-> (age_r < 3'h4) || s_axi_bvalid_out;
   endproperty
   property p_cmp_hold;
      $changed({cmp_mode_out, cmp_power_on_out}) |-> (age_r < 3'h4) || s_axi_bvalid_out;
   endproperty
   property p_rd_hi;
      s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000;
   endproperty
   property p_r_hold;
      s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
   endproperty
   property p_b_hold;
      s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("outputs not cleared");
   a_cmp_pwr: assert property (p_cmp_pwr) else $error("comparator power wrong");
   a_int_ref: assert property (p_int_ref) else $error("reference routing wrong");
   a_ref_hold: assert property (p_ref_hold) else $error("reference moved alone");
   a_cmp_hold: assert property (p_cmp_hold) else $error("comparator moved alone");
   a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   c_int_ref: cover property (cmp_use_int_ref_out);
   c_pin2: cover property (reference_pin2_connect_out);
   c_low_on: cover property (cmp_power_on_out && reference_low_range_out);
endmodule // comparator_vref_control_monitor

bind comparator_vref_control comparator_vref_control_monitor i_comparator_vref_control_monitor (.*);

/* File: tb/comparator_vref_control_test.sv */
`timescale 1ns/100ps
`include "cmp_vref_regs.vh"
module comparator_vref_control_test;
   reg sys_clk_in = 1'b0;
   reg rst_n_in = 1'b0;
   reg [9:0] s_axi_awaddr_in = 10'h000;
   reg [9:0] s_axi_araddr_in = 10'h000;
   reg [31:0] s_axi_wdata_in = 32'h00000000;
   reg [3:0] s_axi_wstrb_in = 4'h1;
   reg s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
   reg s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
   reg first_cmp_raw_in = 1'b0, second_cmp_raw_in = 1'b0;
   wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   wire s_axi_rvalid_out, cmp_power_on_out, cmp_input_switch_out, cmp_use_int_ref_out;
   wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
   wire [31:0] s_axi_rdata_out;
   wire [2:0] cmp_mode_out;
   wire cmp_pin_out_en_out, reference_power_on_out, reference_low_range_out;
   wire [3:0] reference_tap_select_out;
   wire reference_pin2_connect_out, wake_out, cpu_irq_out, irq_out;
   integer fails = 0, cmp_count = 0, cyc = 0, i, n;
   reg [31:0] seed = 32'hF312B4C6, r;
   reg [34:0] expq[$];
   reg [34:0] e;
   reg [7:0] last_ref;
   comparator_vref_control i_comparator_vref_control (.*);
   always #50 sys_clk_in = ~sys_clk_in;
   task automatic tick(input integer k);
      repeat (k) @(posedge sys_clk_in);
   endtask
   task automatic check(input string nm, input [31:0] ex, input [31:0] got);
      cmp_count = cmp_count + 1;
      if (got !== ex) begin
         fails = fails + 1;
         $display("BAD %0s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic wr(input [7:0] idx, input [7:0] d, input [1:0] rs);
      tick(1);
      s_axi_awaddr_in <= {idx, 2'b00};
      s_axi_wdata_in <= {24'h000000, d};
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      tick(1);
      while (s_axi_bvalid_out !== 1'b1) begin
         if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
         tick(1);
      end
      s_axi_awvalid_in <= 1'b0;
      s_axi_wvalid_in <= 1'b0;
      s_axi_bready_in <= 1'b0;
      check("bresp", {30'h0, rs}, {30'h0, s_axi_bresp_out});
   endtask
   // The observer below compares read answers against these notes in order
   task automatic rd(input [7:0] idx, input [1:0] rs, input [7:0] d, input ign);
      expq.push_back({ign, rs, 24'h000000, d});
      tick(1);
      s_axi_araddr_in <= {idx, 2'b00};
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      tick(1);
      while (s_axi_arready_out !== 1'b1) tick(1);
      s_axi_arvalid_in <= 1'b0;
      while (s_axi_rvalid_out !== 1'b1) tick(1);
      s_axi_rready_in <= 1'b0;
   endtask
   always @(posedge sys_clk_in) begin
      if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in && expq.size() > 0) begin
         e = expq.pop_front();
         check("rresp", {30'h0, e[33:32]}, {30'h0, s_axi_rresp_out});
         if (!e[34]) check("rdata", e[31:0], s_axi_rdata_out);
      end
   end
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         report_and_stop;
      end
   end
   initial begin
      tick(3);
      rst_n_in <= 1'b1;
      rd(`IDX_REFERENCE_CONTROL, 2'h0, 8'h00, 1'b0);
      rd(`IDX_COMPARATOR_CONTROL, 2'h0, 8'h00, 1'b0);
      rd(`IDX_PORT_A_DIRECTION, 2'h0, 8'hFF, 1'b0);
      wr(`IDX_REFERENCE_CONTROL, 8'hFF, 2'h0);
      rd(`IDX_REFERENCE_CONTROL, 2'h0, 8'hEF, 1'b0);
      check("ref", 32'h0000007F, {25'h0, reference_power_on_out, reference_low_range_out,
         reference_pin2_connect_out, reference_tap_select_out});
      wr(`IDX_PORT_A_DIRECTION, 8'hFB, 2'h0);
      tick(3);
      check("pin2", 32'h00000000, {31'h0, reference_pin2_connect_out});
      for (i = 0; i < 16; i = i + 1) begin
         r = $random(seed);
         last_ref = {r[7:5], 1'b0, i[3:0]};
         wr(`IDX_REFERENCE_CONTROL, {r[7:4], i[3:0]}, 2'h0);
         rd(`IDX_REFERENCE_CONTROL, 2'h0, last_ref, 1'b0);
         check("tap", {26'h0, reference_power_on_out, reference_low_range_out,
            reference_tap_select_out}, {26'h0, r[7], r[5], i[3:0]});
      end
      $display("reference test done");
      for (i = 0; i < 8; i = i + 1) begin
         wr(`IDX_COMPARATOR_CONTROL, {4'h0, i[0], i[2:0]}, 2'h0);
         rd(`IDX_COMPARATOR_CONTROL, 2'h0, {4'h0, i[0], i[2:0]}, 1'b0);
         check("mode", {25'h0, i[0], i == 6, i != 0 && i != 7, i == 2, i[2:0]},
            {25'h0, cmp_input_switch_out, cmp_pin_out_en_out, cmp_power_on_out,
            cmp_use_int_ref_out, cmp_mode_out});
         check("ref kept", {28'h0, reference_tap_select_out}, 32'h0000000F);
      end
      $display("mode test done");
      wr(`IDX_COMPARATOR_CONTROL, 8'h03, 2'h0);
      wr(`IDX_PERIPHERAL_IRQ_ENABLES, 8'h40, 2'h0);
      wr(`IDX_INTERRUPT_CONTROL, 8'hC0, 2'h0);
      rd(`IDX_COMPARATOR_CONTROL, 2'h0, 8'h03, 1'b0);
      wr(`IDX_PERIPHERAL_IRQ_FLAGS, 8'h00, 2'h0);
      wr(`IDX_IRQ_STATUS, 8'h03, 2'h0);
      wr(`IDX_IRQ_MASK, 8'h01, 2'h0);
      last_ref = {1'b0, last_ref[6:0]};
      wr(`IDX_REFERENCE_CONTROL, last_ref, 2'h0);
      wr(`IDX_SLEEP_CONTROL, 8'h01, 2'h0);
      first_cmp_raw_in <= 1'b1;
      n = 0;
      while (wake_out !== 1'b1 && n < 50) begin
         tick(1);
         n = n + 1;
      end
      check("wake", {31'h0, wake_out}, 32'h00000001);
      tick(2);
      check("irqs", {30'h0, cpu_irq_out, irq_out}, 32'h00000003);
      rd(`IDX_COMPARATOR_CONTROL, 2'h0, 8'h43, 1'b0);
      rd(`IDX_REFERENCE_CONTROL, 2'h0, last_ref, 1'b0);
      rd(`IDX_PERIPHERAL_IRQ_FLAGS, 2'h0, 8'h40, 1'b0);
      wr(`IDX_PERIPHERAL_IRQ_FLAGS, 8'h00, 2'h0);
      wr(`IDX_IRQ_STATUS, 8'h03, 2'h0);
      tick(3);
      check("cleared", {30'h0, cpu_irq_out, irq_out}, 32'h00000000);
      second_cmp_raw_in <= 1'b1;
      tick(5);
      wr(`IDX_IRQ_MASK, 8'h00, 2'h0);
      tick(3);
      check("masked", {31'h0, irq_out}, 32'h00000000);
      wr(`IDX_IRQ_MASK, 8'h01, 2'h0);
      tick(3);
      check("unmasked", {31'h0, irq_out}, 32'h00000001);
      rd(`IDX_COMPARATOR_CONTROL, 2'h0, 8'hC3, 1'b0);
      wr(`IDX_IRQ_STATUS, 8'h03, 2'h0);
      tick(3);
      check("w1c", {31'h0, irq_out}, 32'h00000000);
      $display("interrupt test done");
      rd(8'hB0, 2'h2, 8'h00, 1'b1);
      wr(8'hB0, 8'hFF, 2'h2);
      $display("refusal test done");
      rst_n_in <= 1'b0;
      tick(2);
      check("in reset", {30'h0, cmp_power_on_out, reference_power_on_out}, 32'h0);
      rst_n_in <= 1'b1;
      rd(`IDX_REFERENCE_CONTROL, 2'h0, 8'h00, 1'b0);
      rd(`IDX_COMPARATOR_CONTROL, 2'h0, 8'h00, 1'b0);
      tick(1);
      $display("reset test done");
      report_and_stop;
   end
endmodule // comparator_vref_control_test
